/* File: inc/vac_regs.vh */
// Register map and field constants for the video converter control bank.
// Assumes byte-wide registers reached over an 8-bit address register port.
`ifndef VAC_REGS_VH
`define VAC_REGS_VH

// Register addresses
`define VAC_ADDR_CONV_CTRL 8'h30
`define VAC_ADDR_RED_GAIN 8'h31
`define VAC_ADDR_GREEN_GAIN 8'h32

// Reset values (bit 5 set in every mapped register; read, pad and sync values are zero)
`define VAC_CONV_CTRL_RST 8'h20
`define VAC_COARSE_RST 8'h20
`define VAC_UNMAPPED_READ 8'h00
`define VAC_PAD_RST 8'h00
`define VAC_SYNC_RST 2'h0

// Converter control field positions
`define VAC_OUT_EN_BIT 7
`define VAC_CAPTURE_BIT 6
`define VAC_INV_DIS_BIT 5
`define VAC_FORCE_BIT 4
`define VAC_CLAMP_POL_BIT 3
`define VAC_CLAMP_SRC_BIT 2
`define VAC_AMP_OFF_BIT 1
`define VAC_DAC_OFF_BIT 0

// Coarse gain field
`define VAC_GAIN_MSB 1
`define VAC_GAIN_LSB 0

// Register select codes from the address decoder
`define VAC_SEL_NONE 2'h0
`define VAC_SEL_CTRL 2'h1
`define VAC_SEL_RED 2'h2
`define VAC_SEL_GREEN 2'h3

// Converter output width: three channels of eight bits
`define VAC_CHAN_BITS 8
`define VAC_NUM_CHAN 3

`endif

/* File: rtl/vac_control_regs.v */
// Control register bank for a three-channel video converter: output stage,
// clamp source and polarity, power-down bits and red/green coarse gain.
// Assumes the serial-bus front end presents decoded byte accesses on the
// register port in the clk domain; converter data arrives on clk as well.
//
// Operation
// - Output enable 0 puts all converter pads in high-impedance; reset 0.
// - Invert-disable 0 inverts output data, 1 passes it true; reset 1.
// - Force 1 drives all outputs low or high per invert-disable.
// - Capture-mode bit stored, read back, presented to the core; reset 0.
// - Clamp polarity 0 means active high, 1 active low; reset 0.
// - Clamp source 0 picks internal clamp, 1 the external pin; reset 0.
// - Video amplifier disable 1 powers the amplifier down; reset 0.
// - Fine-ref DAC off 1 turns DACs off, top-reference pins external.
// - Red and green coarse registers hold a two-bit gain code, reset 0.
//
// Hazards and limits
// Pad enables and pad data share one flop stage, so they switch together
// and the pads never show a half-updated word.
// The clamp pin is asynchronous and passes two flops; the internal clamp
// is already on clk and goes straight to the mux.
// Reserved coarse bits are stored exactly as written; keeping them at
// their legal values is left to software.
// Reads have no side effects, so software may poll any register freely.
// A write and a read in one cycle: the read returns the old value.
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.vh"

module vac_control_regs (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port from the serial-bus front end
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Converter core data and pads
  input wire [23:0] conv_data_in,
  output wire [23:0] conv_pad_out,
  output wire [23:0] conv_pad_oe,
  // Clamp sources and result
  input wire int_clamp,
  input wire ext_clamp_pin,
  output reg clamp_active,
  // Analog controls
  output wire capture_mode,
  output wire video_amp_off,
  output wire fine_ref_dac_off,
  output wire [1:0] red_gain_step,
  output wire [1:0] green_gain_step
);

  // Address decode shared by the write and read paths
  function [1:0] reg_select;
    input [7:0] addr;
    begin
      if (addr == `VAC_ADDR_CONV_CTRL)
        reg_select = `VAC_SEL_CTRL;
      else if (addr == `VAC_ADDR_RED_GAIN)
        reg_select = `VAC_SEL_RED;
      else if (addr == `VAC_ADDR_GREEN_GAIN)
        reg_select = `VAC_SEL_GREEN;
      else
        reg_select = `VAC_SEL_NONE;
    end
  endfunction

  // Synchroniser, register bank and pad stage state
  reg [1:0] rst_pipe;
  wire rst_sync_b;
  reg [7:0] conv_ctrl;
  reg [7:0] red_coarse;
  reg [7:0] green_coarse;
  reg [1:0] clamp_pipe;
  reg [23:0] pad_data;
  reg [23:0] pad_oe;
  // Decoder results and field taps
  wire [1:0] wr_sel;
  wire [1:0] rd_sel;
  wire out_en;
  wire inv_dis;
  wire force_out;
  wire clamp_src;

  // Reset: asserted at once, released through two flops
  // Release is synchronous, so no flop sees a runt reset edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe <= `VAC_SYNC_RST;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_b = rst_pipe[1];

  assign wr_sel = reg_select(reg_addr);
  assign rd_sel = reg_select(reg_addr);

  // Register writes; unmapped addresses are dropped silently
  // All eight bits are kept, reserved ones included
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      conv_ctrl <= `VAC_CONV_CTRL_RST;
      red_coarse <= `VAC_COARSE_RST;
      green_coarse <= `VAC_COARSE_RST;
    end
    else if (reg_wr)
    begin
      if (wr_sel == `VAC_SEL_CTRL)
        conv_ctrl <= reg_wdata;
      else if (wr_sel == `VAC_SEL_RED)
        red_coarse <= reg_wdata;
      else if (wr_sel == `VAC_SEL_GREEN)
        green_coarse <= reg_wdata;
    end
  end

  // Read data one cycle after the strobe; reserved bits read as written
  // Unmapped reads answer zero with a valid pulse, never stall
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      reg_rdata <= `VAC_UNMAPPED_READ;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (rd_sel == `VAC_SEL_CTRL)
          reg_rdata <= conv_ctrl;
        else if (rd_sel == `VAC_SEL_RED)
          reg_rdata <= red_coarse;
        else if (rd_sel == `VAC_SEL_GREEN)
          reg_rdata <= green_coarse;
        else
          reg_rdata <= `VAC_UNMAPPED_READ;
      end
    end
  end

  // Field views
  // Analog controls come straight from the bank, no extra latency
  assign out_en = conv_ctrl[`VAC_OUT_EN_BIT];
  assign inv_dis = conv_ctrl[`VAC_INV_DIS_BIT];
  assign force_out = conv_ctrl[`VAC_FORCE_BIT];
  assign capture_mode = conv_ctrl[`VAC_CAPTURE_BIT];
  assign video_amp_off = conv_ctrl[`VAC_AMP_OFF_BIT];
  assign fine_ref_dac_off = conv_ctrl[`VAC_DAC_OFF_BIT];
  assign red_gain_step = red_coarse[`VAC_GAIN_MSB:`VAC_GAIN_LSB];
  assign green_gain_step = green_coarse[`VAC_GAIN_MSB:`VAC_GAIN_LSB];

  // Output stage per channel; one flop stage so pads switch cleanly
  // Pads leave reset tristated and low
  genvar ch;
  generate
    for (ch = 0; ch < `VAC_NUM_CHAN; ch = ch + 1)
    begin : g_chan
      wire [7:0] raw;
      assign raw = conv_data_in[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS];
      always @(posedge clk or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
        begin
          pad_data[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <= `VAC_PAD_RST;
          pad_oe[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <= `VAC_PAD_RST;
        end
        else
        begin
          // Enable alone decides the drive, so tristate beats force
          pad_oe[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <=
            {`VAC_CHAN_BITS{out_en}};
          if (force_out)
            pad_data[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <=
              {`VAC_CHAN_BITS{inv_dis}};
          else if (inv_dis)
            pad_data[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <= raw;
          else
            pad_data[ch*`VAC_CHAN_BITS +: `VAC_CHAN_BITS] <= ~raw;
        end
      end
    end
  endgenerate

  assign conv_pad_out = pad_data;
  assign conv_pad_oe = pad_oe;

  // External clamp pin is asynchronous; second flop is the only reader
  // Costs two cycles of clamp latency in exchange for safe sampling
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      clamp_pipe <= `VAC_SYNC_RST;
    else
      clamp_pipe <= {clamp_pipe[0], ext_clamp_pin};
  end

  // Clamp source and polarity; output is active high in all modes
  // Flop after the mux hides glitches when the source bit changes
  assign clamp_src = conv_ctrl[`VAC_CLAMP_SRC_BIT] ? clamp_pipe[1] :
    int_clamp;
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      clamp_active <= 1'b0;
    else
      clamp_active <= clamp_src ^ conv_ctrl[`VAC_CLAMP_POL_BIT];
  end

endmodule // vac_control_regs
`default_nettype wire

/* File: verification/vac_control_regs_props.sv */
// Port checker for the video converter control bank.
// Bound to vac_control_regs; mirrors writes in a small shadow.
`timescale 1ns/1ps
`default_nettype none
module vac_control_regs_props (
  // Clock, reset, register port
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  // Pads and clamp
  input wire [23:0] conv_data_in,
  input wire [23:0] conv_pad_out,
  input wire [23:0] conv_pad_oe,
  input wire int_clamp,
  input wire ext_clamp_pin,
  input wire clamp_active,
  // Analog controls
  input wire capture_mode,
  input wire video_amp_off,
  input wire fine_ref_dac_off,
  input wire [1:0] red_gain_step,
  input wire [1:0] green_gain_step
);
  reg [2:0] rs;
  reg [7:0] sh [0:2];
  wire hit = reg_addr[7:2] == 6'h0c && reg_addr[1:0] != 2'h3;
  wire [7:0] rd_exp = hit ? sh[reg_addr[1:0]] : 8'h00;
  wire [7:0] c = sh[0];
  // Shadow; checks wait out the design's own reset synchroniser
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rs <= 3'h0;
      sh[0] <= 8'h20;
      sh[1] <= 8'h20;
      sh[2] <= 8'h20;
    end
    else
    begin
      rs <= {rs[1:0], 1'b1};
      if (reg_wr && hit)
        sh[reg_addr[1:0]] <= reg_wdata;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rs[2]);
  property p_oe; conv_pad_oe == {24{$past(c[7])}}; endproperty
  a_oe: assert property (p_oe) else $error("pad enable");
  property p_pad; conv_pad_out == ($past(c[4]) ? {24{$past(c[5])}} :
    $past(c[5]) ? $past(conv_data_in) : ~$past(conv_data_in)); endproperty
  a_pad: assert property (p_pad) else $error("pad data");
  property p_ctl; {capture_mode, video_amp_off, fine_ref_dac_off} ==
    {c[6], c[1], c[0]}; endproperty
  a_ctl: assert property (p_ctl) else $error("control");
  property p_gain; {red_gain_step, green_gain_step} ==
    {sh[1][1:0], sh[2][1:0]}; endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_rd; reg_rd |=> reg_rvalid && reg_rdata == $past(rd_exp);
  endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rv0; !reg_rd |=> !reg_rvalid; endproperty
  a_rv0: assert property (p_rv0) else $error("stray valid");
  property p_ci; !$past(c[2]) |->
    clamp_active == ($past(int_clamp) ^ $past(c[3])); endproperty
  a_ci: assert property (p_ci) else $error("int clamp");
  property p_ce; $past(c[2]) |->
    clamp_active == ($past(ext_clamp_pin, 3) ^ $past(c[3])); endproperty
  a_ce: assert property (p_ce) else $error("ext clamp");
  c_force: cover property (c[7] && c[4]);
  c_ext: cover property (c[2] && c[3]);
  c_rw: cover property (reg_rd && reg_wr);
endmodule // vac_control_regs_props
bind vac_control_regs vac_control_regs_props u_props (.*);
`default_nettype wire

/* File: verification/vac_control_regs_tb.sv */
// Self-checking bench for the video converter control bank.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module vac_control_regs_tb;
  logic clk, rst_b, reg_wr, reg_rd, int_clamp, ext_clamp_pin;
  logic [7:0] reg_addr, reg_wdata;
  logic [23:0] conv_data_in, d;
  logic [31:0] lf;
  logic [7:0] m [0:3];
  wire [7:0] reg_rdata;
  wire reg_rvalid, clamp_active, capture_mode, video_amp_off;
  wire fine_ref_dac_off;
  wire [23:0] conv_pad_out, conv_pad_oe;
  wire [1:0] red_gain_step, green_gain_step;
  int mismatches, comparisons, i;
  vac_control_regs u_dut (.*);
  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [23:0] ep(input [7:0] c, input [23:0] x);
    ep = c[4] ? {24{c[5]}} : (c[5] ? x : ~x);
  endfunction
  task cmp(input string n, input [23:0] e, input [23:0] g);
  begin
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  end
  endtask
  // Model tracks mapped bytes only; 0x33 stays zero
  task wr(input [7:0] a, input [7:0] v);
  begin
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    if (a != 8'h33)
      m[a[1:0]] = v;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp("rdata", {16'h0, m[a[1:0]]}, {16'h0, reg_rdata});
    cmp("rvalid", 24'h1, {23'h0, reg_rvalid});
    @(posedge clk);
  end
  endtask
  task final_report;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Reset, register walk, then pad and clamp traffic
  initial
  begin
    lf = 32'h13c9;
    {rst_b, reg_wr, reg_rd, int_clamp, ext_clamp_pin} = 5'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    conv_data_in = 24'h0;
    for (i = 0; i < 4; i++)
      m[i] = i < 3 ? 8'h20 : 8'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i++)
      rd(8'h30 + i[7:0]);
    cmp("oe", 24'h0, conv_pad_oe);
    $display("reset test done");
    for (i = 0; i < 40; i++)
    begin
      lf = nx(lf);
      wr(8'h30 + lf[1:0], lf[1:0] == 0 ? lf[15:8] : {6'h08, lf[9:8]});
      rd(8'h30 + lf[5:4]);
      cmp("ctl", {17'h0, m[0][6], m[0][1], m[0][0], m[1][1:0], m[2][1:0]},
        {17'h0, capture_mode, video_amp_off, fine_ref_dac_off,
        red_gain_step, green_gain_step});
    end
    // Write and read in one cycle: the read returns the old value
    reg_addr <= 8'h31;
    reg_wdata <= 8'h23;
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 cmp("rdata", {16'h0, m[1]}, {16'h0, reg_rdata});
    m[1] = 8'h23;
    @(posedge clk);
    rd(8'h31);
    $display("register test done");
    for (i = 0; i < 384; i++)
    begin
      lf = nx(lf);
      if (i % 16 == 0)
        wr(8'h30, i < 128 ? {i[6], lf[30], i[5:4], lf[27:24]} : lf[31:24]);
      d = lf[23:0];
      conv_data_in <= d;
      int_clamp <= lf[24];
      ext_clamp_pin <= lf[26];
      @(posedge clk);
      #1 cmp("pad", ep(m[0], d), conv_pad_out);
      cmp("oe", {24{m[0][7]}}, conv_pad_oe);
      if (!m[0][2])
        cmp("clamp", {23'h0, lf[24] ^ m[0][3]}, {23'h0, clamp_active});
      @(posedge clk);
    end
    $display("pad test done");
    final_report;
  end
endmodule // vac_control_regs_tb
`default_nettype wire
